// ===== hw/swsel_link.sv
// single-wire link engine: tokens, flags, groups, timeouts
module swsel_link
    import swsel_pkg::*;
#(
    parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF,
    parameter int WDOG_CYC    = WDOG_CYC_DEF,
    parameter bit TWO_WIRE    = 1'b0
) (
    input  wire logic       clk,        // 10 MHz system clock
    input  wire logic       reset,      // synchronous, active high
    input  wire logic       sda_in,     // data wire level
    output logic            sda_out,    // data wire drive value (0)
    output logic            sda_oe,     // high while pulling low
    output logic            gpo,        // secondary output pin
    output logic            cmd_valid,  // command group complete
    output logic [7:0]      cmd_len,    // command group byte count
    input  wire logic       exec_done,  // command finished pulse
    input  wire logic       gpo_wr,     // query_command_a sets pin
    input  wire logic       gpo_val,    // new pin level
    input  wire logic       rsp_we,     // result byte write
    input  wire logic [5:0] rsp_addr,   // result byte address
    input  wire logic [7:0] rsp_data,   // result byte
    input  wire logic       chip_mode_wdog_off, // chip_mode_field bit
    output logic            idle_mode,  // device idle
    output logic            sleep_mode, // device asleep
    output logic            vol_clear,  // sleep reset pulse
    output logic            wdog_on     // watchdog running
);
    logic sda_s1_r, sda_s2_r, sda_d_r;
    swsel_mode_e mode_r;
    logic [15:0] low_cnt_r;
    logic [15:0] gap_cnt_r;
    logic        second_r;
    logic        bit_pend_r;
    logic [2:0]  bit_idx_r;
    logic [7:0]  sh_r;
    logic [5:0]  byte_idx_r;
    logic [7:0]  cnt_r;
    logic [31:0] tmo_r;
    logic [31:0] wdog_r;
    logic [15:0] tx_tmr_r;
    logic [5:0]  tx_idx_r;
    logic [2:0]  tx_bit_r;
    logic [7:0]  tx_byte_r;
    logic [7:0]  tx_len_r;
    logic        rsp_ok_r;
    logic        gpo_r;
    logic        fall, rise, wake_tok, bit_tok, bit_val, to_fire, wd_fire;
    logic        mem_we;
    logic [5:0]  mem_waddr, mem_raddr;
    logic [7:0]  mem_wdata, mem_rdata;
    logic        xmit_buf_r;

    // two-stage synchroniser on the wire, then edge history
    always_ff @(posedge clk) begin
        if (reset) begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
        end
    end
    assign fall = sda_d_r & ~sda_s2_r;
    assign rise = ~sda_d_r & sda_s2_r;

    // low pulse length measurement
    always_ff @(posedge clk) begin
        if (reset || fall) begin
            low_cnt_r <= 16'h0000;
        end else if (!sda_s2_r && low_cnt_r != 16'hFFFF) begin
            low_cnt_r <= low_cnt_r + 16'h0001;
        end
    end

    // wake is a long low pulse; illegal between short and wake
    assign wake_tok = rise && (low_cnt_r >= 16'(WAKE_LOW_CYC));
    logic short_low;
    assign short_low = rise && (low_cnt_r <= 16'(ZLO_MAX_CYC));

    // token decode: second pulse inside window marks zero
    always_ff @(posedge clk) begin
        if (reset || mode_r == SWSEL_BUSY) begin
            gap_cnt_r  <= 16'h0000;
            second_r   <= 1'b0;
            bit_pend_r <= 1'b0;
        end else if (fall) begin
            // window runs from the start pulse, not from the second pulse
            if (bit_pend_r && gap_cnt_r < 16'(BIT_WIN_CYC)) begin
                second_r  <= 1'b1;
                gap_cnt_r <= gap_cnt_r + 16'h0001;
            end else begin
                bit_pend_r <= 1'b1;
                second_r   <= 1'b0;
                gap_cnt_r  <= 16'h0000;
            end
        end else if (bit_pend_r) begin
            if (gap_cnt_r == 16'(BIT_WIN_CYC)) begin
                bit_pend_r <= 1'b0;
            end
            gap_cnt_r <= gap_cnt_r + 16'h0001;
        end
    end
    assign bit_tok = bit_pend_r && gap_cnt_r == 16'(BIT_WIN_CYC)
                     && sda_s2_r;
    assign bit_val = ~second_r;

    // mode sequencing, flags and group reception
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r     <= SWSEL_SLEEP;
            bit_idx_r  <= 3'd0;
            sh_r       <= 8'h00;
            byte_idx_r <= 6'd0;
            cnt_r      <= 8'h00;
            cmd_valid  <= 1'b0;
            cmd_len    <= 8'h00;
            rsp_ok_r   <= 1'b0;
            xmit_buf_r <= 1'b0;
        end else begin
            cmd_valid <= 1'b0;
            if (exec_done) begin
                rsp_ok_r <= 1'b1;
            end
            if (wake_tok && mode_r != SWSEL_BUSY) begin
                // wake from rest, or link reset while awake
                mode_r     <= SWSEL_FLAG;
                bit_idx_r  <= 3'd0;
                byte_idx_r <= 6'd0;
                xmit_buf_r <= (mode_r == SWSEL_SLEEP);
            end else if (to_fire || wd_fire) begin
                mode_r   <= SWSEL_SLEEP;
                rsp_ok_r <= 1'b0;
            end else begin
                case (mode_r)
                    SWSEL_FLAG: if (bit_tok) begin
                        sh_r      <= {bit_val, sh_r[7:1]};
                        bit_idx_r <= bit_idx_r + 3'd1;
                        if (bit_idx_r == 3'd7) begin
                            case ({bit_val, sh_r[7:1]})
                                FLAG_CMD: begin
                                    mode_r     <= SWSEL_RXGRP;
                                    byte_idx_r <= 6'd0;
                                    rsp_ok_r   <= 1'b0;
                                end
                                FLAG_XMIT: mode_r <= SWSEL_TURN;
                                FLAG_IDLE: begin
                                    mode_r   <= SWSEL_IDLE;
                                    rsp_ok_r <= 1'b0;
                                end
                                FLAG_SLEEP: begin
                                    mode_r   <= SWSEL_SLEEP;
                                    rsp_ok_r <= 1'b0;
                                end
                                default: mode_r <= SWSEL_FLAG;
                            endcase
                        end
                    end
                    SWSEL_RXGRP: if (bit_tok) begin
                        sh_r      <= {bit_val, sh_r[7:1]};
                        bit_idx_r <= bit_idx_r + 3'd1;
                        if (bit_idx_r == 3'd7) begin
                            byte_idx_r <= byte_idx_r + 6'd1;
                            if (byte_idx_r == 6'd0) begin
                                cnt_r <= {bit_val, sh_r[7:1]};
                            end
                            if (byte_idx_r != 6'd0 &&
                                {2'b00, byte_idx_r} == cnt_r - 8'd1) begin
                                mode_r    <= SWSEL_BUSY;
                                cmd_valid <= 1'b1;
                                cmd_len   <= cnt_r;
                            end
                        end
                    end
                    SWSEL_BUSY: if (exec_done) begin
                        mode_r     <= SWSEL_FLAG;
                        xmit_buf_r <= 1'b0;
                    end
                    SWSEL_TURN: if (tx_tmr_r == 16'(TURN_CYC)) begin
                        mode_r <= SWSEL_TXGRP;
                    end
                    SWSEL_TXGRP: if (tx_idx_r == tx_len_r[5:0] &&
                                     tx_bit_r == 3'd0 &&
                                     tx_tmr_r == 16'h0000) begin
                        mode_r <= SWSEL_FLAG;
                    end
                    default: ;
                endcase
            end
        end
    end

    // input bytes go to the shared buffer, results come back
    assign mem_we    = (mode_r == SWSEL_RXGRP && bit_tok &&
                        bit_idx_r == 3'd7) || rsp_we;
    assign mem_waddr = rsp_we ? rsp_addr : byte_idx_r;
    assign mem_wdata = rsp_we ? rsp_data : {bit_val, sh_r[7:1]};
    // read one byte ahead while sending, so the next byte is ready
    assign mem_raddr = (mode_r == SWSEL_TXGRP) ? tx_idx_r + 6'd1 : tx_idx_r;

    swsel_mem u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // turnaround and output token timing
    always_ff @(posedge clk) begin
        if (reset || (mode_r != SWSEL_TURN && mode_r != SWSEL_TXGRP)) begin
            tx_tmr_r  <= 16'h0000;
            tx_idx_r  <= 6'd0;
            tx_bit_r  <= 3'd0;
            tx_len_r  <= 8'd4;
            tx_byte_r <= 8'h00;
        end else if (mode_r == SWSEL_TURN) begin
            tx_tmr_r <= (tx_tmr_r == 16'(TURN_CYC)) ? 16'h0000
                                                    : tx_tmr_r + 16'h0001;
            if (tx_tmr_r == 16'(TURN_CYC)) begin
                // results when available else status group
                tx_len_r  <= rsp_ok_r ? mem_rdata : 8'd4;
                tx_byte_r <= rsp_ok_r ? mem_rdata : 8'd4;
            end
        end else if (tx_tmr_r == 16'(OUT_BIT_CYC - 1)) begin
            tx_tmr_r <= 16'h0000;
            tx_bit_r <= tx_bit_r + 3'd1;
            tx_byte_r <= {1'b0, tx_byte_r[7:1]};
            if (tx_bit_r == 3'd7) begin
                tx_idx_r <= tx_idx_r + 6'd1;
                if (!rsp_ok_r) begin
                    // status group: count, status, two check bytes
                    tx_byte_r <= (tx_idx_r == 6'd0)
                               ? (xmit_buf_r ? STAT_WAKE : 8'h00)
                               : 8'h00;
                end else begin
                    tx_byte_r <= mem_rdata;
                end
            end
        end else begin
            tx_tmr_r <= tx_tmr_r + 16'h0001;
        end
    end

    // open-drain drive: start pulse, plus second pulse for zero
    always_comb begin
        sda_out = 1'b0;
        sda_oe  = 1'b0;
        if (mode_r == SWSEL_TXGRP && tx_idx_r != tx_len_r[5:0]) begin
            if (tx_tmr_r < 16'(OUT_PULSE_CYC)) begin
                sda_oe = 1'b1;
            end else if (!tx_byte_r[0] &&
                         tx_tmr_r >= 16'(2*OUT_PULSE_CYC) &&
                         tx_tmr_r < 16'(3*OUT_PULSE_CYC)) begin
                sda_oe = 1'b1;
            end
        end
    end

    // inactivity timeout, restarted on each legal token
    always_ff @(posedge clk) begin
        if (reset || mode_r == SWSEL_BUSY || mode_r == SWSEL_SLEEP ||
            mode_r == SWSEL_IDLE || mode_r == SWSEL_TXGRP ||
            mode_r == SWSEL_TURN) begin
            tmo_r <= 32'd0;
        end else if (bit_tok || short_low || wake_tok) begin
            tmo_r <= 32'd0;
        end else if (bit_pend_r || mode_r == SWSEL_RXGRP ||
                     (!sda_s2_r && !short_low)) begin
            tmo_r <= tmo_r + 32'd1;
        end
    end
    assign to_fire = tmo_r >= 32'(TIMEOUT_CYC);

    // watchdog from wake, held off while idle or disabled
    always_ff @(posedge clk) begin
        if (reset || mode_r == SWSEL_SLEEP || mode_r == SWSEL_IDLE ||
            chip_mode_wdog_off || wake_tok) begin
            wdog_r <= 32'd0;
        end else begin
            wdog_r <= wdog_r + 32'd1;
        end
    end
    assign wd_fire = wdog_r >= 32'(WDOG_CYC);

    // general-purpose output, low from reset
    always_ff @(posedge clk) begin
        if (reset) begin
            gpo_r <= 1'b0;
        end else if (gpo_wr && !TWO_WIRE) begin
            gpo_r <= gpo_val;
        end
    end
    assign gpo        = TWO_WIRE ? 1'b0 : gpo_r;
    assign idle_mode  = (mode_r == SWSEL_IDLE);
    assign sleep_mode = (mode_r == SWSEL_SLEEP);
    assign vol_clear  = to_fire || wd_fire;
    assign wdog_on    = wdog_r != 32'd0;

    // checks
    property p_idle_wdog;
        @(posedge clk) disable iff (reset)
        idle_mode |=> !wdog_on;
    endproperty
    a_idle_wdog: assert property (p_idle_wdog)
        else $error("watchdog ran in idle");
    property p_busy_quiet;
        @(posedge clk) disable iff (reset)
        mode_r == SWSEL_BUSY |-> tmo_r == 32'd0;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("timeout counted while busy");
    property p_gpo_reset;
        @(posedge clk) $past(reset) |-> !gpo;
    endproperty
    a_gpo_reset: assert property (p_gpo_reset)
        else $error("gpo not low after reset");
    property p_tmo_sleep;
        @(posedge clk) disable iff (reset)
        to_fire && !wake_tok |=> sleep_mode;
    endproperty
    a_tmo_sleep: assert property (p_tmo_sleep)
        else $error("timeout did not sleep");
    sequence s_turn_start;
        mode_r != SWSEL_TURN ##1 mode_r == SWSEL_TURN;
    endsequence
    property p_turn;
        @(posedge clk) disable iff (reset)
        s_turn_start |-> !sda_oe [*8];
    endproperty
    a_turn: assert property (p_turn)
        else $error("drove during turnaround");
    property p_reply_start;
        @(posedge clk) disable iff (reset)
        mode_r == SWSEL_TURN && tx_tmr_r == 16'(TURN_CYC) |=> sda_oe;
    endproperty
    a_reply_start: assert property (p_reply_start)
        else $error("reply did not start after turnaround");
    property p_sleep_hold;
        @(posedge clk) disable iff (reset)
        sleep_mode && !wake_tok |=> sleep_mode;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("left sleep without wake");
    property p_idle_hold;
        @(posedge clk) disable iff (reset)
        idle_mode && !wake_tok |=> idle_mode;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("left idle without wake");
    property p_no_tx_asleep;
        @(posedge clk) disable iff (reset)
        sleep_mode |-> !sda_oe;
    endproperty
    a_no_tx_asleep: assert property (p_no_tx_asleep)
        else $error("drove wire while asleep");
endmodule // swsel_link

// ===== hw/swsel_mem.sv
// small byte buffer for the link input/output group
module swsel_mem
    import swsel_pkg::*;
#(
    parameter int DW = 8,
    parameter int AW = BUF_AW
) (
    input  wire logic          clk,   // system clock
    input  wire logic          we,    // write strobe
    input  wire logic [AW-1:0] waddr, // write address
    input  wire logic [DW-1:0] wdata, // write data
    input  wire logic [AW-1:0] raddr, // read address
    output logic      [DW-1:0] rdata  // registered read data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule // swsel_mem

// ===== pkg/swsel_pkg.sv
// constants and types for the single-wire secure element link
package swsel_pkg;
    localparam int CLK_HZ            = 10_000_000;
    localparam int CLK_NS            = 100;
    // flag and status codes
    localparam logic [7:0] FLAG_CMD   = 8'h77;
    localparam logic [7:0] FLAG_XMIT  = 8'h88;
    localparam logic [7:0] FLAG_IDLE  = 8'hBB;
    localparam logic [7:0] FLAG_SLEEP = 8'hCC;
    localparam logic [7:0] STAT_WAKE  = 8'h11;
    // times in ns or ms and derived cycle counts
    localparam int WAKE_LOW_NS        = 60_000;
    localparam int WAKE_LOW_CYC       = (WAKE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int ZLO_MAX_NS         = 4_560;
    localparam int ZLO_MAX_CYC        = ZLO_MAX_NS / CLK_NS + 4;
    localparam int OUT_PULSE_NS       = 6_000;
    localparam int OUT_PULSE_CYC      = OUT_PULSE_NS / CLK_NS;
    localparam int OUT_BIT_NS         = 54_000;
    localparam int OUT_BIT_CYC        = OUT_BIT_NS / CLK_NS;
    localparam int TURN_NS            = 96_000;
    localparam int TURN_CYC           = TURN_NS / CLK_NS;
    localparam int BIT_WIN_NS         = 20_000;
    localparam int BIT_WIN_CYC        = BIT_WIN_NS / CLK_NS;
    localparam int TIMEOUT_MS         = 65;
    localparam int TIMEOUT_CYC_DEF    = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int WDOG_MS            = 1300;
    localparam int WDOG_CYC_DEF       = WDOG_MS * (CLK_HZ / 1000);
    localparam int BUF_DEPTH          = 64;
    localparam int BUF_AW             = 6;
    typedef enum logic [2:0] {
        SWSEL_SLEEP, SWSEL_IDLE, SWSEL_FLAG, SWSEL_RXGRP,
        SWSEL_BUSY, SWSEL_TURN, SWSEL_TXGRP
    } swsel_mode_e;
endpackage

// ===== testbench/swsel_host.sv
// host bus master model driving and sampling the single data wire
module swsel_host (
    input  wire logic       clk,      // system clock
    input  wire logic       wire_lvl, // resolved wire level
    output logic            h_oe,     // high while host pulls low
    output logic            rx_stb,   // received byte strobe
    output logic [7:0]      rx_byte   // received byte
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc = 0;     // free cycle count
    int t_last = 0;  // start of last host bit
    int t_first = 0; // first device fall of a reply
    // released wire, no strobe
    initial begin
        h_oe = 1'b0;
        rx_stb = 1'b0;
        rx_byte = 8'h00;
    end
    // cycle counter for turnaround timing
    always @(posedge clk) cyc <= cyc + 1;
    // hold the wire low for n cycles, then let the pull-up win
    task automatic low(input int n);
        @(negedge clk) h_oe = 1'b1;
        repeat (n) @(negedge clk);
        h_oe = 1'b0;
    endtask
    // long low well past the wake threshold
    task automatic wake();
        low(700);
        repeat (300) @(negedge clk);
    endtask
    // one token per bit, a second pulse marks a zero
    task automatic send_bit(input logic b);
        t_last = cyc;
        low(43);
        if (!b) begin
            repeat (43) @(negedge clk);
            low(43);
        end
        repeat (b ? 176 : 90) @(negedge clk);
    endtask
    // eight tokens, lowest bit first
    task automatic send_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) send_bit(v[i]);
    endtask
    // sample one reply byte; a lone falling edge is a one
    task automatic recv_byte(input int wmax);
        int n;
        int f;
        logic p;
        for (int i = 0; i < 8; i++) begin
            n = 0;
            while (wire_lvl && n < wmax) begin
                @(posedge clk);
                n++;
            end
            if (i == 0) t_first = cyc;
            f = 0;
            p = 1'b0;
            repeat (250) begin
                @(posedge clk);
                if (!wire_lvl && p) f++;
                p = wire_lvl;
            end
            rx_byte[i] = (f == 0);
            wmax = 600;
        end
        @(negedge clk) rx_stb = 1'b1;
        @(negedge clk) rx_stb = 1'b0;
    endtask
endmodule // swsel_host

// ===== testbench/swsel_link_tb.sv
// self-checking bench for the single-wire link engine
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %0t: got %0h want %0h", $time, (g), (e)); end end
module swsel_link_tb
    import swsel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TMO = 2000;  // shortened io timeout
    localparam int WDG = 6000;  // shortened watchdog
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        exec_done = 1'b0;
    logic        gpo_wr = 1'b0;
    logic        gpo_val;
    logic        rsp_we = 1'b0;
    logic        wd_off = 1'b1;
    logic        vc_seen = 1'b0;
    logic [5:0]  rsp_addr;
    logic [7:0]  rsp_data;
    logic [31:0] lfsr = 32'hBE2B;
    logic        sda_out, sda_oe, gpo, cmd_valid, h_oe, rx_stb, wire_lvl;
    logic        idle_mode, sleep_mode, vol_clear, wdog_on;
    logic [7:0]  cmd_len, rx_byte, e;
    logic [7:0]  exp_q[$];
    logic [7:0]  grp[4];
    int          error_cnt = 0;
    int          n_checks = 0;
    always #50 clk = ~clk;
    // open-drain wire with pull-up
    assign wire_lvl = !(h_oe || (sda_oe && !sda_out));
    swsel_link #(.TIMEOUT_CYC(TMO), .WDOG_CYC(WDG), .TWO_WIRE(1'b0)) dut (
        .clk(clk), .reset(reset), .sda_in(wire_lvl), .sda_out(sda_out),
        .sda_oe(sda_oe), .gpo(gpo), .cmd_valid(cmd_valid),
        .cmd_len(cmd_len), .exec_done(exec_done), .gpo_wr(gpo_wr),
        .gpo_val(gpo_val), .rsp_we(rsp_we), .rsp_addr(rsp_addr),
        .rsp_data(rsp_data), .chip_mode_wdog_off(wd_off),
        .idle_mode(idle_mode), .sleep_mode(sleep_mode),
        .vol_clear(vol_clear), .wdog_on(wdog_on));
    swsel_host host (.clk(clk), .wire_lvl(wire_lvl), .h_oe(h_oe),
        .rx_stb(rx_stb), .rx_byte(rx_byte));
    // next pseudo-random state
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // compare each reply byte or command length with the oldest note
    always @(posedge clk) begin
        if (vol_clear === 1'b1) vc_seen <= 1'b1;
        if (rx_stb === 1'b1 || cmd_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            `CHK(rx_stb ? rx_byte : cmd_len, e)
        end
    end
    task automatic idle_for(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    // note a four-byte reply, ask for it and time the turnaround
    task automatic reply(input logic [7:0] b1);
        int d;
        exp_q = {exp_q, 8'h04, b1, 8'h00, 8'h00};
        host.send_byte(FLAG_XMIT);
        host.recv_byte(1500);
        d = host.t_first - host.t_last;
        `CHK(d >= 640 && d <= 1310, 1'b1)
        repeat (3) host.recv_byte(600);
        idle_for(930);
    endtask
    // device must not touch the wire for n cycles
    task automatic quiet(input int n);
        logic s;
        s = 1'b0;
        repeat (n) begin
            @(posedge clk);
            s = s | sda_oe;
        end
        `CHK(s, 1'b0)
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        rsp_we = 1'b1;
        rsp_addr = a;
        rsp_data = d;
        @(negedge clk) rsp_we = 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // main sequence of scenarios
    initial begin
        gpo_val = 1'b0;
        rsp_addr = 6'h00;
        rsp_data = 8'h00;
        idle_for(16);
        reset = 1'b0;
        idle_for(2);
        `CHK({sleep_mode, idle_mode, wdog_on, vol_clear}, 4'h8)
        `CHK({gpo, sda_oe, cmd_valid}, 3'h0)
        done("reset");
        host.send_byte(FLAG_XMIT);
        quiet(1500);
        done("asleep");
        host.wake();
        reply(STAT_WAKE);
        done("wake status");
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            @(negedge clk);
            gpo_wr = 1'b1;
            gpo_val = lfsr[0];
            @(negedge clk) gpo_wr = 1'b0;
            idle_for(2);
            `CHK(gpo, gpo_val)
        end
        repeat (3) host.send_bit(1'b0);
        host.wake();
        host.send_byte(8'h5A);
        quiet(300);
        lfsr = nxt(lfsr);
        grp = '{8'h04, lfsr[7:0], 8'h00, 8'h00};
        exp_q.push_back(8'h04);
        host.send_byte(FLAG_CMD);
        foreach (grp[i]) host.send_byte(grp[i]);
        `CHK(exp_q.size(), 0)
        host.send_byte(FLAG_XMIT);
        quiet(2500);
        lfsr = nxt(lfsr);
        grp[1] = lfsr[7:0];
        foreach (grp[i]) wr(6'(i), grp[i]);
        @(negedge clk) exec_done = 1'b1;
        @(negedge clk) exec_done = 1'b0;
        reply(grp[1]);
        done("command");
        host.send_byte(FLAG_IDLE);
        wd_off = 1'b0;
        idle_for(4);
        `CHK({idle_mode, wdog_on}, 2'b10)
        host.send_byte(FLAG_XMIT);
        quiet(1500);
        host.wake();
        `CHK({idle_mode, wdog_on}, 2'b01)
        done("idle");
        vc_seen = 1'b0;
        idle_for(WDG - 1500);
        `CHK(sleep_mode, 1'b0)
        idle_for(3000);
        `CHK({sleep_mode, vc_seen}, 2'b11)
        done("watchdog");
        wd_off = 1'b1;
        host.wake();
        host.send_byte(FLAG_SLEEP);
        idle_for(4);
        `CHK({sleep_mode, idle_mode}, 2'b10)
        done("sleep");
        host.wake();
        vc_seen = 1'b0;
        host.send_byte(FLAG_CMD);
        host.send_byte(8'h04);
        host.send_byte(8'h3C);
        idle_for(TMO - 500);
        `CHK(sleep_mode, 1'b0)
        idle_for(1000);
        `CHK({sleep_mode, vc_seen}, 2'b11)
        done("timeout");
        report_and_stop();
    end
    // cut a hung run short
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("ERROR %0t: run timed out", $time);
        report_and_stop();
    end
endmodule // swsel_link_tb
